// ---- group_select.sv ----
/*
 group_select: one output group; picks the selection source, clamps it to the
 high limit, fetches that pattern and masks bits beyond the width.
 Assumes pattern words and settings arrive on the same clock.
*/
`timescale 1ns/1ps
module group_select import pattern_gen_pkg::*; #(
	parameter int NUM_PATTERNS = DEF_NUM_PATTERNS,
	parameter int PATTERN_BITS = DEF_PATTERN_BITS
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic src_wired,
	input wire logic [SEL_W-1:0] src_value,
	input wire logic [SEL_W-1:0] local_sel,
	input wire logic [LIM_W-1:0] high_limit,
	input wire logic [LIM_W-1:0] out_width,
	input wire logic [NUM_PATTERNS*PATTERN_BITS-1:0] pattern_flat,
	output logic [IDX_W-1:0] sel_index_reg,
	output logic [PATTERN_BITS-1:0] active_output_word
);
	logic [IDX_W-1:0] sel_index_next;
	logic [PATTERN_BITS-1:0] word_next;
	logic [SEL_W-1:0] raw_sel;
	logic [LIM_W-1:0] lim_eff;
	logic [SEL_W-1:0] max_idx;
	logic [PATTERN_BITS-1:0] fetched;

	initial begin
		if (NUM_PATTERNS > (1 << IDX_W) || NUM_PATTERNS >= (1 << LIM_W)) begin
			$error("group_select: NUM_PATTERNS too large");
		end
	end

	always_comb begin
		raw_sel = src_wired ? src_value : local_sel;
		// limit 0 or above the store means no restriction
		if (high_limit == '0 || int'(high_limit) > NUM_PATTERNS) begin
			lim_eff = LIM_W'(NUM_PATTERNS);
		end else begin
			lim_eff = high_limit;
		end
		max_idx = SEL_W'(lim_eff - LIM_W'(1));
		if (raw_sel > max_idx) begin
			sel_index_next = max_idx[IDX_W-1:0];
		end else begin
			sel_index_next = raw_sel[IDX_W-1:0];
		end
		fetched = pattern_flat[sel_index_next*PATTERN_BITS +: PATTERN_BITS];
		for (int b = 0; b < PATTERN_BITS; b++) begin
			word_next[b] = (b < int'(out_width)) ? fetched[b] : 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sel_index_reg <= '0;
			active_output_word <= '0;
		end else begin
			sel_index_reg <= sel_index_next;
			active_output_word <= word_next;
		end
	end
endmodule

// ---- pattern_gen_checker.sv ----
/*
 pattern_gen_checker: port assertions for pattern_generator.
 assumes one clock, synchronous srst; bound at the foot of this file.
*/
`timescale 1ns/1ps
module pattern_gen_checker import pattern_gen_pkg::*; #(
	parameter int NUM_GROUPS = DEF_NUM_GROUPS,
	parameter int PATTERN_BITS = DEF_PATTERN_BITS
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [NUM_GROUPS-1:0] sel_src_wired,
	input wire logic [NUM_GROUPS*SEL_W-1:0] sel_src_value,
	input wire logic [NUM_GROUPS*PATTERN_BITS-1:0] pattern_out,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	logic [NUM_GROUPS-1:0] w_q;
	logic [NUM_GROUPS*SEL_W-1:0] v_q;
	logic [1:0] quiet_reg;
	// cycles since the last source change or bus write
	always_ff @(posedge ref_clk) begin
		w_q <= sel_src_wired;
		v_q <= sel_src_value;
		if (srst || w_q != sel_src_wired || v_q != sel_src_value || s_axi_awvalid
			|| s_axi_wvalid) begin
			quiet_reg <= 2'h0;
		end else if (quiet_reg != 2'h3) begin
			quiet_reg <= quiet_reg + 2'h1;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_wr_busy;
		!s_axi_awready && !s_axi_wready;
	endsequence
	property p_wr_busy;
		s_wr_take |=> s_wr_busy ##1 s_axi_bvalid;
	endproperty
	a_wr_busy: assert property (p_wr_busy) else $error("write answer late");
	property p_wr_free;
		$rose(s_axi_bvalid) |-> s_axi_awready && s_axi_wready;
	endproperty
	a_wr_free: assert property (p_wr_free) else $error("write path not free");
	property p_b_done;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_b_done: assert property (p_b_done) else $error("write answer stuck");
	property p_rd_resp;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
	property p_r_done;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
	endproperty
	a_r_done: assert property (p_r_done) else $error("read answer stuck");
	// read data only ever answers an address taken one edge before
	property p_r_cause;
		$rose(s_axi_rvalid) |-> $past(s_axi_arvalid) && $past(s_axi_arready);
	endproperty
	a_r_cause: assert property (p_r_cause) else $error("read answer without request");
	property p_rst;
		disable iff (1'b0) srst |=> pattern_out == '0 && !s_axi_bvalid && !s_axi_rvalid;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not cleared");
	property p_quiet;
		quiet_reg == 2'h3 |-> $stable(pattern_out);
	endproperty
	a_quiet: assert property (p_quiet) else $error("output moved alone");
endmodule
bind pattern_generator pattern_gen_checker #(.NUM_GROUPS(NUM_GROUPS),
	.PATTERN_BITS(PATTERN_BITS)) chk_i (.ref_clk, .srst, .sel_src_wired,
	.sel_src_value, .pattern_out, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready);

// ---- pattern_gen_pkg.sv ----
/*
 pattern_gen_pkg: constants shared by the pattern generator and its group selector.
 Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package pattern_gen_pkg;
	localparam int DEF_NUM_PATTERNS = 16;
	localparam int DEF_PATTERN_BITS = 16;
	localparam int DEF_NUM_GROUPS = 2;
	localparam int SEL_W = 8;
	localparam int IDX_W = 4;
	localparam int LIM_W = 5;
	localparam int ADDR_W = 8;

	// register map, byte addresses
	localparam logic [ADDR_W-1:0] GROUP_BASE = 8'h00;
	localparam logic [ADDR_W-1:0] GROUP_STRIDE = 8'h10;
	localparam logic [1:0] GREG_SEL = 2'h0;
	localparam logic [1:0] GREG_LIMIT = 2'h1;
	localparam logic [1:0] GREG_WIDTH = 2'h2;
	localparam logic [1:0] GREG_OUTPUT = 2'h3;
	localparam logic [ADDR_W-1:0] PATTERN_BASE = 8'h40;

	// fields of the selection register on read
	localparam int SEL_LOCAL_LSB = 0;
	localparam int SEL_EFFECTIVE_LSB = 8;
	localparam int SEL_WIRED_BIT = 16;

	// reset values
	localparam logic [SEL_W-1:0] SEL_RESET = 8'h00;
	localparam logic [LIM_W-1:0] LIMIT_RESET = 5'h10;
	localparam logic [LIM_W-1:0] WIDTH_RESET = 5'h10;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- pattern_generator.sv ----
/*
 pattern_generator: sixteen stored output patterns, two output groups, AXI4-Lite
 register access. Assumes the selection sources and their wired flags come from
 logic on ref_clk, so they are read without synchronisers.
*/
`timescale 1ns/1ps
// Behaviour
// - sixteen patterns, indexed 0 to 15, are stored and each can be selected.
// - every pattern holds up to sixteen on/off output bits.
// - two output groups each have their own selection and active pattern.
// - a selection of N drives the group outputs with pattern N.
// - a wired source sets the selection, read-only; the local value counts only unwired.
// - a high limit L permits only patterns 0 to L-1 in that group; a limit of 0 permits every pattern.
// - a width setting limits how many pattern bits reach the outputs.
// - each group's current output word is readable.
module pattern_generator import pattern_gen_pkg::*; #(
	parameter int NUM_PATTERNS = DEF_NUM_PATTERNS,
	parameter int PATTERN_BITS = DEF_PATTERN_BITS,
	parameter int NUM_GROUPS = DEF_NUM_GROUPS
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [NUM_GROUPS-1:0] sel_src_wired,
	input wire logic [NUM_GROUPS*SEL_W-1:0] sel_src_value,
	output logic [NUM_GROUPS*PATTERN_BITS-1:0] pattern_out,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	initial begin
		if (NUM_PATTERNS < 1 || NUM_PATTERNS > DEF_NUM_PATTERNS) begin
			$error("pattern_generator: NUM_PATTERNS out of range");
		end
		if (PATTERN_BITS < 1 || PATTERN_BITS > 16) begin
			$error("pattern_generator: PATTERN_BITS out of range");
		end
		if (NUM_GROUPS < 1 || NUM_GROUPS * GROUP_STRIDE > PATTERN_BASE) begin
			$error("pattern_generator: NUM_GROUPS out of range");
		end
	end

	// pattern store and per-group settings
	logic [PATTERN_BITS-1:0] pattern_reg [NUM_PATTERNS];
	logic [PATTERN_BITS-1:0] pattern_next [NUM_PATTERNS];
	logic [SEL_W-1:0] local_sel_reg [NUM_GROUPS];
	logic [SEL_W-1:0] local_sel_next [NUM_GROUPS];
	logic [LIM_W-1:0] limit_reg [NUM_GROUPS];
	logic [LIM_W-1:0] limit_next [NUM_GROUPS];
	logic [LIM_W-1:0] width_reg [NUM_GROUPS];
	logic [LIM_W-1:0] width_next [NUM_GROUPS];
	logic [NUM_PATTERNS*PATTERN_BITS-1:0] pattern_flat;
	logic [IDX_W-1:0] sel_index [NUM_GROUPS];

	// write channel state
	logic aw_held_reg, aw_held_next;
	logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
	logic w_held_reg, w_held_next;
	logic [31:0] w_data_reg, w_data_next;
	logic [3:0] w_strb_reg, w_strb_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic do_write;

	// read channel state
	logic rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0] rresp_reg, rresp_next;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_PATTERNS; gi++) begin : g_flat
			assign pattern_flat[gi*PATTERN_BITS +: PATTERN_BITS] = pattern_reg[gi];
		end
		for (gi = 0; gi < NUM_GROUPS; gi++) begin : g_group
			// each group is independent, so both can drive at once
			group_select #(
				.NUM_PATTERNS(NUM_PATTERNS),
				.PATTERN_BITS(PATTERN_BITS)
			) u_group (
				.ref_clk(ref_clk),
				.srst(srst),
				.src_wired(sel_src_wired[gi]),
				.src_value(sel_src_value[gi*SEL_W +: SEL_W]),
				.local_sel(local_sel_reg[gi]),
				.high_limit(limit_reg[gi]),
				.out_width(width_reg[gi]),
				.pattern_flat(pattern_flat),
				.sel_index_reg(sel_index[gi]),
				.active_output_word(pattern_out[gi*PATTERN_BITS +: PATTERN_BITS])
			);
		end
	endgenerate

	// merge a bus word into a register under byte strobes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = data[b*8 +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic is_group(input logic [ADDR_W-1:0] a);
		return int'(a) >= int'(GROUP_BASE) &&
			int'(a) < int'(GROUP_BASE) + NUM_GROUPS * int'(GROUP_STRIDE);
	endfunction

	function automatic logic is_pattern(input logic [ADDR_W-1:0] a);
		return int'(a) >= int'(PATTERN_BASE) &&
			int'(a) < int'(PATTERN_BASE) + 4 * NUM_PATTERNS;
	endfunction

	function automatic int group_of(input logic [ADDR_W-1:0] a);
		return (int'(a) - int'(GROUP_BASE)) / int'(GROUP_STRIDE);
	endfunction

	function automatic logic [1:0] greg_of(input logic [ADDR_W-1:0] a);
		return a[3:2];
	endfunction

	function automatic int pattern_of(input logic [ADDR_W-1:0] a);
		return (int'(a) - int'(PATTERN_BASE)) / 4;
	endfunction

	// write path: address and data taken in either order, applied together
	always_comb begin
		aw_held_next = aw_held_reg;
		aw_addr_next = aw_addr_reg;
		w_held_next = w_held_reg;
		w_data_next = w_data_reg;
		w_strb_next = w_strb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		for (int p = 0; p < NUM_PATTERNS; p++) begin
			pattern_next[p] = pattern_reg[p];
		end
		for (int g = 0; g < NUM_GROUPS; g++) begin
			local_sel_next[g] = local_sel_reg[g];
			limit_next[g] = limit_reg[g];
			width_next[g] = width_reg[g];
		end
		if (s_axi_awvalid && s_axi_awready) begin
			aw_held_next = 1'b1;
			aw_addr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_held_next = 1'b1;
			w_data_next = s_axi_wdata;
			w_strb_next = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		if (do_write) begin
			aw_held_next = 1'b0;
			w_held_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = RESP_OKAY;
			if (aw_addr_reg[1:0] != 2'h0) begin
				bresp_next = RESP_SLVERR;
			end else if (is_pattern(aw_addr_reg)) begin
				// whole word write sets every bit on or off at once
				pattern_next[pattern_of(aw_addr_reg)] = PATTERN_BITS'(merge(
					32'(pattern_reg[pattern_of(aw_addr_reg)]), w_data_reg, w_strb_reg));
			end else if (is_group(aw_addr_reg)) begin
				case (greg_of(aw_addr_reg))
					GREG_SEL: begin
						// kept even while wired; only used once unwired
						local_sel_next[group_of(aw_addr_reg)] = SEL_W'(merge(
							32'(local_sel_reg[group_of(aw_addr_reg)]), w_data_reg,
							w_strb_reg));
					end
					GREG_LIMIT: begin
						limit_next[group_of(aw_addr_reg)] = LIM_W'(merge(
							32'(limit_reg[group_of(aw_addr_reg)]), w_data_reg, w_strb_reg));
					end
					GREG_WIDTH: begin
						width_next[group_of(aw_addr_reg)] = LIM_W'(merge(
							32'(width_reg[group_of(aw_addr_reg)]), w_data_reg, w_strb_reg));
					end
					default: begin
						// output word is read-only; writes ignored
					end
				endcase
			end else begin
				bresp_next = RESP_SLVERR;
			end
		end
	end

	assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
	assign s_axi_awready = !aw_held_reg;
	assign s_axi_wready = !w_held_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;

	// read path: one cycle from address to data
	always_comb begin
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		if (s_axi_rvalid && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_next = 1'b1;
			rdata_next = 32'h0000_0000;
			rresp_next = RESP_OKAY;
			if (s_axi_araddr[1:0] != 2'h0) begin
				rresp_next = RESP_SLVERR;
			end else if (is_pattern(s_axi_araddr)) begin
				rdata_next = 32'(pattern_reg[pattern_of(s_axi_araddr)]);
			end else if (is_group(s_axi_araddr)) begin
				case (greg_of(s_axi_araddr))
					GREG_SEL: begin
						rdata_next[SEL_LOCAL_LSB +: SEL_W] = local_sel_reg[group_of(s_axi_araddr)];
						rdata_next[SEL_EFFECTIVE_LSB +: IDX_W] = sel_index[group_of(s_axi_araddr)];
						rdata_next[SEL_WIRED_BIT] = sel_src_wired[group_of(s_axi_araddr)];
					end
					GREG_LIMIT: begin
						rdata_next = 32'(limit_reg[group_of(s_axi_araddr)]);
					end
					GREG_WIDTH: begin
						rdata_next = 32'(width_reg[group_of(s_axi_araddr)]);
					end
					default: begin
						rdata_next = 32'(pattern_out[group_of(s_axi_araddr)*PATTERN_BITS
							+: PATTERN_BITS]);
					end
				endcase
			end else begin
				rresp_next = RESP_SLVERR;
			end
		end
	end

	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			aw_held_reg <= 1'b0;
			aw_addr_reg <= '0;
			w_held_reg <= 1'b0;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= RESP_OKAY;
			for (int p = 0; p < NUM_PATTERNS; p++) begin
				pattern_reg[p] <= '0;
			end
			for (int g = 0; g < NUM_GROUPS; g++) begin
				local_sel_reg[g] <= SEL_RESET;
				limit_reg[g] <= LIMIT_RESET;
				width_reg[g] <= WIDTH_RESET;
			end
		end else begin
			aw_held_reg <= aw_held_next;
			aw_addr_reg <= aw_addr_next;
			w_held_reg <= w_held_next;
			w_data_reg <= w_data_next;
			w_strb_reg <= w_strb_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
			for (int p = 0; p < NUM_PATTERNS; p++) begin
				pattern_reg[p] <= pattern_next[p];
			end
			for (int g = 0; g < NUM_GROUPS; g++) begin
				local_sel_reg[g] <= local_sel_next[g];
				limit_reg[g] <= limit_next[g];
				width_reg[g] <= width_next[g];
			end
		end
	end
endmodule

// ---- sel_source_model.sv ----
/*
 sel_source_model: wired selection source per group.
 assumes ref_clk; commands come from the bench.
*/
`timescale 1ns/1ps
module sel_source_model import pattern_gen_pkg::*; (
	input wire logic ref_clk,
	input wire logic [1:0] wire_cmd,
	input wire logic [2*SEL_W-1:0] value_cmd,
	output logic [1:0] sel_src_wired,
	output logic [2*SEL_W-1:0] sel_src_value
);
	// unwired value inverted so a stale value never looks valid
	always_ff @(posedge ref_clk) begin
		sel_src_wired <= wire_cmd;
		for (int g = 0; g < 2; g++) begin
			sel_src_value[g*SEL_W +: SEL_W] <= wire_cmd[g] ? value_cmd[g*SEL_W +: SEL_W]
				: ~value_cmd[g*SEL_W +: SEL_W];
		end
	end
endmodule

// ---- testbench.sv ----
/*
 testbench: AXI4-Lite and selection source stimulus for pattern_generator.
 assumes the package register map and a 20 MHz ref_clk.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin errors++; \
	$display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module testbench import pattern_gen_pkg::*;;
	logic ref_clk = 0, srst = 1, awv = 0, wv = 0, arv = 0, awr, wr_rdy, arr, bv, rv;
	logic [1:0] wire_cmd = 0, sel_src_wired, bresp, rresp, resp;
	logic [15:0] value_cmd = 0, sel_src_value;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, rdv, pattern_out;
	int errors = 0, check_count = 0, p;
	pattern_generator pattern_generator_i (.ref_clk, .srst, .sel_src_wired, .sel_src_value,
		.pattern_out, .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
		.s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
		.s_axi_rready(1'b1));
	sel_source_model sel_source_model_i (.ref_clk, .wire_cmd, .value_cmd, .sel_src_wired,
		.sel_src_value);
	initial begin
		forever #25 ref_clk = ~ref_clk;
	end
	function automatic logic [7:0] ga(int g, logic [1:0] r);
		return GROUP_BASE + 8'(g) * GROUP_STRIDE + {4'h0, r, 2'h0};
	endfunction
	function automatic logic [7:0] pa(int i);
		return PATTERN_BASE + 8'(4 * i);
	endfunction
	function automatic logic [15:0] pv(int i);
		return 16'(i * 16'h0111) ^ 16'ha5c3;
	endfunction
	task complete_run;
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// bready tied high, so the answer is taken at the edge it is seen
	task wr_reg(input logic [7:0] a, input logic [31:0] d);
		int n;
		logic ap, wp;
		ap = 1;
		wp = 1;
		awaddr <= a;
		wdata <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge ref_clk);
			if (!ap && !wp && bv) break;
			if (ap && awr) begin
				ap = 0;
				awv <= 1'b0;
			end
			if (wp && wr_rdy) begin
				wp = 0;
				wv <= 1'b0;
			end
		end
		resp = bresp;
		if (n == 20) begin
			errors++;
			complete_run();
		end
	endtask
	task rd_reg(input logic [7:0] a);
		int n;
		logic ap;
		ap = 1;
		araddr <= a;
		arv <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge ref_clk);
			if (!ap && rv) break;
			if (ap && arr) begin
				ap = 0;
				arv <= 1'b0;
			end
		end
		rdv = rdata;
		resp = rresp;
		if (n == 20) begin
			errors++;
			complete_run();
		end
	endtask
	// wired change needs model edge plus design edge
	task chk_out(int g, logic [15:0] e);
		repeat (3) @(posedge ref_clk);
		`CHK("pattern_out", e, pattern_out[g*16 +: 16])
		rd_reg(ga(g, GREG_OUTPUT));
		`CHK("output reg", {16'h0, e}, rdv)
	endtask
	initial begin
		repeat (2) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		rd_reg(ga(1, GREG_LIMIT));
		`CHK("limit", 32'h10, rdv)
		rd_reg(ga(1, GREG_WIDTH));
		`CHK("width", 32'h10, rdv)
		for (p = 0; p < 16; p++) wr_reg(pa(p), {16'hffff, pv(p)});
		for (p = 0; p < 16; p++) begin
			rd_reg(pa(p));
			`CHK("pattern", {16'h0, pv(p)}, rdv)
		end
		for (p = 0; p < 16; p++) begin
			wr_reg(ga(0, GREG_SEL), 32'(p));
			wr_reg(ga(1, GREG_SEL), 32'(15 - p));
			chk_out(0, pv(p));
			chk_out(1, pv(15 - p));
		end
		wr_reg(ga(0, GREG_SEL), 32'h9);
		wire_cmd <= 2'b01;
		value_cmd <= 16'h0005;
		chk_out(0, pv(5));
		rd_reg(ga(0, GREG_SEL));
		`CHK("sel fields", 32'h10509, rdv)
		wire_cmd <= 2'b00;
		chk_out(0, pv(9));
		wr_reg(ga(0, GREG_LIMIT), 32'h8);
		wr_reg(ga(0, GREG_SEL), 32'hc);
		chk_out(0, pv(7));
		wire_cmd <= 2'b10;
		value_cmd <= 16'hc800;
		chk_out(1, pv(15));
		wr_reg(ga(1, GREG_WIDTH), 32'h6);
		chk_out(1, pv(15) & 16'h003f);
		wr_reg(ga(1, GREG_WIDTH), 32'h0);
		chk_out(1, 16'h0);
		wr_reg(8'h80, 32'h1);
		`CHK("bresp past last pattern", RESP_SLVERR, resp)
		rd_reg(8'h80);
		`CHK("rresp past last pattern", RESP_SLVERR, resp)
		wr_reg(pa(0) + 8'h1, 32'h0);
		`CHK("bresp unaligned", RESP_SLVERR, resp)
		rd_reg(pa(0));
		`CHK("pattern kept", {16'h0, pv(0)}, rdv)
		wr_reg(ga(0, GREG_OUTPUT), 32'h0);
		`CHK("bresp output reg", RESP_OKAY, resp)
		chk_out(0, pv(7));
		wr_reg(ga(0, GREG_LIMIT), 32'h0);
		chk_out(0, pv(12));
		complete_run();
	end
endmodule
